// *** shared/pms_regs.svh ***
// Purpose: Register map and timing constants of the power mode controller
// Assumes: APB with 32-bit words, one register per aligned word
// Notes: Printed offsets are word indexes; byte address is four times them
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

// Word indexes and byte addresses
`define PMS_IDX_CTRL_ONE 16'hfff0
`define PMS_IDX_CTRL_TWO 16'hfff1
`define PMS_IDX_STATUS 16'hfff2
`define PMS_ADDR_CTRL_ONE {`PMS_IDX_CTRL_ONE, 2'b00}
`define PMS_ADDR_CTRL_TWO {`PMS_IDX_CTRL_TWO, 2'b00}
`define PMS_ADDR_STATUS {`PMS_IDX_STATUS, 2'b00}

// Reset values and writable masks
`define PMS_RST_CTRL_ONE 8'h07
`define PMS_RST_CTRL_TWO 8'hf0
`define PMS_WMASK_CTRL_ONE 8'hfb
`define PMS_WMASK_CTRL_TWO 8'h1f

// Gating word after reset: active high speed, paired serial out of reset
`define PMS_RST_GATE 15'h2fe7

// External interrupt inputs still heard in each low-power mode
`define PMS_IRQ_KEEP_ALL 5'h1f
`define PMS_IRQ_KEEP_WATCH 5'h01
`define PMS_IRQ_KEEP_STBY 5'h03

// Control one fields
`define PMS_SOFTWARE_STANDBY_BIT_BIT 7
`define PMS_WAIT_HI 6
`define PMS_WAIT_LO 4
`define PMS_LOW_SPEED_SELECT_BIT_BIT 3
`define PMS_MA_HI 1
`define PMS_MA_LO 0

// Control two fields
`define PMS_NESEL_BIT 4
`define PMS_DIRECT_TRANSFER_BIT_BIT 3
`define PMS_MEDIUM_SPEED_ON_BIT_BIT 2
`define PMS_SA_HI 1
`define PMS_SA_LO 0

// Settling waits in states, one state per pclk cycle
`define PMS_WAIT_1024 15'h0400
`define PMS_WAIT_2048 15'h0800
`define PMS_WAIT_4096 15'h1000
`define PMS_WAIT_2 15'h0002
`define PMS_WAIT_8 15'h0008
`define PMS_WAIT_16 15'h0010

// Medium speed divider masks (divide minus one)
`define PMS_DIV16_MASK 7'h0f
`define PMS_DIV32_MASK 7'h1f
`define PMS_DIV64_MASK 7'h3f
`define PMS_DIV128_MASK 7'h7f

`endif

// *** shared/pms_pkg.sv ***
// Purpose: Types shared by the power mode controller
// Assumes: Included after pms_regs.svh where constants are needed
// Notes: Mode codes are also read back through the status register
package pms_pkg;

	typedef enum logic [3:0] {
		PMS_ACTIVE_HS = 4'h0,
		PMS_ACTIVE_MS = 4'h1,
		PMS_SLEEP_HS = 4'h2,
		PMS_SLEEP_MS = 4'h3,
		PMS_WATCH = 4'h4,
		PMS_SUBACTIVE = 4'h5,
		PMS_SUBSLEEP = 4'h6,
		PMS_STANDBY = 4'h7,
		PMS_SETTLE = 4'h8
	} pms_mode_t;

endpackage

// *** logic/pms_apb_regs.sv ***
// Purpose: APB slave holding the two control registers and a status word
// Assumes: Zero wait states, pready always high
// Notes: Reserved control register bits read as one and ignore writes; upper bits of each word read as zero
`timescale 1ns/10ps
`include "pms_regs.svh"

module pms_apb_regs import pms_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] status,
	output logic [7:0] ctrl_one_r,
	output logic [7:0] ctrl_two_r
);

	logic [7:0] ctrl_one_nxt;
	logic [7:0] ctrl_two_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic hit_one;
	logic hit_two;
	logic hit_stat;
	logic access;

	assign access = psel & penable;
	assign hit_one = (paddr[17:0] == `PMS_ADDR_CTRL_ONE) && (paddr[31:18] == 14'h0000);
	assign hit_two = (paddr[17:0] == `PMS_ADDR_CTRL_TWO) && (paddr[31:18] == 14'h0000);
	assign hit_stat = (paddr[17:0] == `PMS_ADDR_STATUS) && (paddr[31:18] == 14'h0000);
	assign pready = 1'b1;
	assign pslverr = access & ~(hit_one | hit_two | (hit_stat & ~pwrite));
	assign prdata = prdata_r;

	always_comb begin
		ctrl_one_nxt = ctrl_one_r;
		ctrl_two_nxt = ctrl_two_r;
		prdata_nxt = prdata_r;
		if (access && pwrite && hit_one) begin
			ctrl_one_nxt = (pwdata[7:0] & `PMS_WMASK_CTRL_ONE) | (`PMS_RST_CTRL_ONE & ~`PMS_WMASK_CTRL_ONE);
		end
		if (access && pwrite && hit_two) begin
			ctrl_two_nxt = (pwdata[7:0] & `PMS_WMASK_CTRL_TWO) | (`PMS_RST_CTRL_TWO & ~`PMS_WMASK_CTRL_TWO);
		end
		if (psel && !penable && !pwrite) begin
			// Read data captured in setup so it stands from a flop in access
			if (hit_one) begin
				prdata_nxt = {24'h00_0000, ctrl_one_r};
			end else if (hit_two) begin
				prdata_nxt = {24'h00_0000, ctrl_two_r};
			end else if (hit_stat) begin
				prdata_nxt = {24'h00_0000, status};
			end else begin
				prdata_nxt = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_one_r <= `PMS_RST_CTRL_ONE;
			ctrl_two_r <= `PMS_RST_CTRL_TWO;
			prdata_r <= 32'h0000_0000;
		end else begin
			ctrl_one_r <= ctrl_one_nxt;
			ctrl_two_r <= ctrl_two_nxt;
			prdata_r <= prdata_nxt;
		end
	end

endmodule // pms_apb_regs

// *** logic/pms_wake_timer.sv ***
// Purpose: Oscillator settling wait after leaving standby, watch or subactive
// Assumes: One state equals one pclk cycle
// Notes: Wait code is sampled at start; later writes do not stretch it
`timescale 1ns/10ps
`include "pms_regs.svh"

module pms_wake_timer import pms_pkg::*; #(
	parameter logic [14:0] WAIT_8192 = 15'h2000,
	parameter logic [14:0] WAIT_16384 = 15'h4000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [2:0] wait_sel,
	output logic done
);

	logic [14:0] cnt_r;
	logic [14:0] cnt_nxt;
	logic busy_r;
	logic busy_nxt;
	logic done_r;
	logic done_nxt;

	function automatic logic [14:0] wait_len(input logic [2:0] sel);
		unique case (sel)
			3'b000: wait_len = WAIT_8192;
			3'b001: wait_len = WAIT_16384;
			3'b010: wait_len = `PMS_WAIT_1024;
			3'b011: wait_len = `PMS_WAIT_2048;
			3'b100: wait_len = `PMS_WAIT_4096;
			3'b101: wait_len = `PMS_WAIT_2;
			3'b110: wait_len = `PMS_WAIT_8;
			3'b111: wait_len = `PMS_WAIT_16;
		endcase
	endfunction

	assign done = done_r;

	always_comb begin
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (start) begin
			cnt_nxt = wait_len(wait_sel) - 15'h0001;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			if (cnt_r == 15'h0001 || cnt_r == 15'h0000) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
			cnt_nxt = cnt_r - 15'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 15'h0000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

endmodule // pms_wake_timer

// *** logic/pms_top.sv ***
// Purpose: Operating mode controller with APB control registers
// Assumes: sleep_req and wake_req come from pclk logic, pins do not
// Notes: Run/reset outputs are levels that gate peripheral clocks
`timescale 1ns/10ps
`include "pms_regs.svh"

module pms_top import pms_pkg::*; #(
	parameter logic [14:0] WAIT_8192 = 15'h2000,
	parameter logic [14:0] WAIT_16384 = 15'h4000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_req,
	input wire logic wake_req,
	input wire logic tmr_a_timebase,
	input wire logic tmr_c_ext_or_w4,
	input wire logic tmr_g_ext_or_w4,
	input wire logic tmr_f_ext_or_w4,
	input wire logic tmr_g_w4,
	input wire logic tmr_f_w4,
	input wire logic ser_one_ext_or_w4,
	input wire logic pser_w2,
	input wire logic wdog_w32,
	input wire logic [4:0] irq_pin,
	input wire logic [7:0] wakeup_input,
	output logic [3:0] mode,
	output logic sysclk_osc_en,
	output logic subclk_osc_en,
	output logic cpu_run,
	output logic cpu_on_subclk,
	output logic ms_tick,
	output logic port_hiz,
	output logic tmr_a_run,
	output logic tmr_c_run,
	output logic tmr_g_run,
	output logic tmr_f_run,
	output logic wdog_run,
	output logic ser_one_run,
	output logic pser_run,
	output logic pser_rst,
	output logic adc_run,
	output logic noise_sample_sel,
	output logic [1:0] subclk_div_sel,
	output logic [4:0] irq_set,
	output logic [7:0] wkp_set
);

	// ------------------------------------------------------------
	// Registers and settling timer
	// ------------------------------------------------------------
	logic [7:0] ctrl_one_r;
	logic [7:0] ctrl_two_r;
	logic [7:0] status;
	logic settle_start;
	logic settle_done;
	logic software_standby_bit;
	logic low_speed_select_bit;
	logic direct_transfer_bit;
	logic medium_speed_on_bit;
	logic [1:0] ma_sel;
	pms_mode_t mode_r;
	pms_mode_t mode_nxt;

	assign software_standby_bit = ctrl_one_r[`PMS_SOFTWARE_STANDBY_BIT_BIT];
	assign low_speed_select_bit = ctrl_one_r[`PMS_LOW_SPEED_SELECT_BIT_BIT];
	assign ma_sel = ctrl_one_r[`PMS_MA_HI:`PMS_MA_LO];
	assign direct_transfer_bit = ctrl_two_r[`PMS_DIRECT_TRANSFER_BIT_BIT];
	assign medium_speed_on_bit = ctrl_two_r[`PMS_MEDIUM_SPEED_ON_BIT_BIT];
	assign status = {4'h0, mode_r};

	pms_apb_regs pms_apb_regs_i (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.status(status),
		.ctrl_one_r(ctrl_one_r),
		.ctrl_two_r(ctrl_two_r)
	);

	pms_wake_timer #(
		.WAIT_8192(WAIT_8192),
		.WAIT_16384(WAIT_16384)
	) pms_wake_timer_i (
		.pclk(pclk),
		.presetn(presetn),
		.start(settle_start),
		.wait_sel(ctrl_one_r[`PMS_WAIT_HI:`PMS_WAIT_LO]),
		.done(settle_done)
	);

	// ------------------------------------------------------------
	// Mode sequencer
	// ------------------------------------------------------------
	function automatic pms_mode_t active_of(input logic ms);
		active_of = ms ? PMS_ACTIVE_MS : PMS_ACTIVE_HS;
	endfunction

	always_comb begin
		mode_nxt = mode_r;
		settle_start = 1'b0;
		unique case (mode_r)
			PMS_ACTIVE_HS, PMS_ACTIVE_MS: begin
				if (sleep_req) begin
					if (direct_transfer_bit && !software_standby_bit && !low_speed_select_bit) begin
						mode_nxt = active_of(medium_speed_on_bit);
					end else if (direct_transfer_bit && software_standby_bit && low_speed_select_bit && tmr_a_timebase) begin
						mode_nxt = PMS_SUBACTIVE;
					end else if (!software_standby_bit) begin
						mode_nxt = medium_speed_on_bit ? PMS_SLEEP_MS : PMS_SLEEP_HS;
					end else if (tmr_a_timebase) begin
						mode_nxt = PMS_WATCH;
					end else begin
						mode_nxt = PMS_STANDBY;
					end
				end
			end
			PMS_SLEEP_HS, PMS_SLEEP_MS: begin
				if (wake_req) begin
					mode_nxt = active_of(medium_speed_on_bit);
				end
			end
			PMS_SUBACTIVE: begin
				if (sleep_req) begin
					if (direct_transfer_bit && software_standby_bit && !low_speed_select_bit && tmr_a_timebase) begin
						mode_nxt = PMS_SETTLE;
						settle_start = 1'b1;
					end else if (software_standby_bit) begin
						mode_nxt = PMS_WATCH;
					end else begin
						mode_nxt = PMS_SUBSLEEP;
					end
				end
			end
			PMS_SUBSLEEP: begin
				if (wake_req) begin
					mode_nxt = PMS_SUBACTIVE;
				end
			end
			PMS_WATCH: begin
				if (wake_req) begin
					if (low_speed_select_bit) begin
						mode_nxt = PMS_SUBACTIVE;
					end else begin
						mode_nxt = PMS_SETTLE;
						settle_start = 1'b1;
					end
				end
			end
			PMS_STANDBY: begin
				if (wake_req) begin
					mode_nxt = PMS_SETTLE;
					settle_start = 1'b1;
				end
			end
			PMS_SETTLE: begin
				if (settle_done) begin
					mode_nxt = active_of(medium_speed_on_bit);
				end
			end
			default: begin
				mode_nxt = PMS_ACTIVE_HS;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= PMS_ACTIVE_HS;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	assign mode = mode_r;

	// ------------------------------------------------------------
	// Medium speed prescaler
	// ------------------------------------------------------------
	logic [6:0] pre_r;
	logic [6:0] pre_nxt;
	logic [6:0] div_mask;
	logic ms_tick_r;
	logic ms_tick_nxt;
	logic ms_mode;

	assign ms_mode = (mode_r == PMS_ACTIVE_MS) || (mode_r == PMS_SLEEP_MS);

	always_comb begin
		unique case (ma_sel)
			2'b00: div_mask = `PMS_DIV16_MASK;
			2'b01: div_mask = `PMS_DIV32_MASK;
			2'b10: div_mask = `PMS_DIV64_MASK;
			2'b11: div_mask = `PMS_DIV128_MASK;
		endcase
		pre_nxt = pre_r + 7'h01;
		// Tick every cycle at high speed so one output serves both modes
		ms_tick_nxt = ms_mode ? ((pre_r & div_mask) == div_mask) : 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r <= 7'h00;
			ms_tick_r <= 1'b0;
		end else begin
			pre_r <= pre_nxt;
			ms_tick_r <= ms_tick_nxt;
		end
	end

	assign ms_tick = ms_tick_r;

	// ------------------------------------------------------------
	// Clock, CPU and peripheral gating per mode
	// ------------------------------------------------------------
	logic is_watch;
	logic is_sub;
	logic is_subact;
	logic is_stby;
	logic is_full;
	logic [14:0] gate_nxt;
	logic [14:0] gate_r;

	assign is_watch = (mode_r == PMS_WATCH);
	assign is_subact = (mode_r == PMS_SUBACTIVE);
	assign is_sub = is_subact || (mode_r == PMS_SUBSLEEP);
	assign is_stby = (mode_r == PMS_STANDBY);
	assign is_full = (mode_r == PMS_ACTIVE_HS) || (mode_r == PMS_ACTIVE_MS) ||
		(mode_r == PMS_SLEEP_HS) || (mode_r == PMS_SLEEP_MS);

	always_comb begin
		gate_nxt = 15'h0000;
		// Oscillator keeps running through settling so the wait has a clock
		gate_nxt[0] = is_full || (mode_r == PMS_SETTLE);
		gate_nxt[1] = 1'b1;
		gate_nxt[2] = (mode_r == PMS_ACTIVE_HS) || (mode_r == PMS_ACTIVE_MS) ||
			is_subact;
		gate_nxt[3] = is_subact;
		gate_nxt[4] = is_stby;
		gate_nxt[5] = is_full || ((is_watch || is_sub) && tmr_a_timebase);
		gate_nxt[6] = is_full || (is_sub && tmr_c_ext_or_w4);
		gate_nxt[7] = is_full || (is_sub && tmr_g_ext_or_w4) ||
			(is_watch && tmr_g_w4);
		gate_nxt[8] = is_full || (is_sub && tmr_f_ext_or_w4) ||
			(is_watch && tmr_f_w4);
		gate_nxt[9] = is_full || (is_subact && wdog_w32);
		gate_nxt[10] = is_full || (is_sub && ser_one_ext_or_w4);
		gate_nxt[11] = is_full || (is_sub && pser_w2);
		gate_nxt[12] = is_watch || is_stby;
		gate_nxt[13] = is_full;
		gate_nxt[14] = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_r <= `PMS_RST_GATE;
		end else begin
			gate_r <= gate_nxt;
		end
	end

	assign sysclk_osc_en = gate_r[0];
	assign subclk_osc_en = gate_r[1];
	assign cpu_run = gate_r[2];
	assign cpu_on_subclk = gate_r[3];
	assign port_hiz = gate_r[4];
	assign tmr_a_run = gate_r[5];
	assign tmr_c_run = gate_r[6];
	assign tmr_g_run = gate_r[7];
	assign tmr_f_run = gate_r[8];
	assign wdog_run = gate_r[9];
	assign ser_one_run = gate_r[10];
	assign pser_run = gate_r[11];
	assign pser_rst = gate_r[12];
	assign adc_run = gate_r[13];
	assign noise_sample_sel = ctrl_two_r[`PMS_NESEL_BIT];
	assign subclk_div_sel = ctrl_two_r[`PMS_SA_HI:`PMS_SA_LO];

	// ------------------------------------------------------------
	// External interrupt and wakeup pin capture
	// ------------------------------------------------------------
	// Pins are asynchronous: two stages before any edge logic
	logic [12:0] pin_s1_r;
	logic [12:0] pin_s2_r;
	logic [12:0] pin_s3_r;
	logic [4:0] irq_keep;
	logic [4:0] irq_set_r;
	logic [4:0] irq_set_nxt;
	logic [7:0] wkp_set_r;
	logic [7:0] wkp_set_nxt;
	logic [12:0] pin_rise;

	assign pin_rise = pin_s2_r & ~pin_s3_r;

	always_comb begin
		irq_keep = `PMS_IRQ_KEEP_ALL;
		if (is_watch) begin
			irq_keep = `PMS_IRQ_KEEP_WATCH;
		end else if (is_stby) begin
			irq_keep = `PMS_IRQ_KEEP_STBY;
		end
		// Ignored requests never reach the flag register
		irq_set_nxt = pin_rise[4:0] & irq_keep;
		wkp_set_nxt = pin_rise[12:5];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= 13'h0000;
			pin_s2_r <= 13'h0000;
			pin_s3_r <= 13'h0000;
			irq_set_r <= 5'b0_0000;
			wkp_set_r <= 8'h00;
		end else begin
			pin_s1_r <= {wakeup_input, irq_pin};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			irq_set_r <= irq_set_nxt;
			wkp_set_r <= wkp_set_nxt;
		end
	end

	assign irq_set = irq_set_r;
	assign wkp_set = wkp_set_r;

endmodule // pms_top

// *** sim/pms_top_asserts.sv ***
// Purpose: Port assertions of the power mode controller
// Assumes: Gating outputs follow mode one edge later
// Notes: Bound to every pms_top instance
`timescale 1ns/10ps
module pms_top_asserts import pms_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] mode,
	input wire logic sysclk_osc_en,
	input wire logic subclk_osc_en,
	input wire logic port_hiz,
	input wire logic tmr_a_timebase,
	input wire logic tmr_a_run,
	input wire logic tmr_c_ext_or_w4,
	input wire logic tmr_c_run,
	input wire logic tmr_g_w4,
	input wire logic tmr_g_run,
	input wire logic pser_w2,
	input wire logic pser_run,
	input wire logic pser_rst,
	input wire logic wdog_w32,
	input wire logic wdog_run,
	input wire logic [4:0] irq_set
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------
	// Gating per mode
	// ------------------
	property p_osc;
		1 |=> subclk_osc_en &&
			sysclk_osc_en == !($past(mode) inside {[PMS_WATCH:PMS_STANDBY]});
	endproperty
	a_osc: assert property (p_osc)
		else $error("oscillator enable wrong for mode");
	property p_hiz;
		1 |=> port_hiz == ($past(mode) == PMS_STANDBY);
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("port_hiz not tied to standby");
	property p_tmr_c;
		mode inside {PMS_SUBACTIVE, PMS_SUBSLEEP}
			|=> tmr_c_run == $past(tmr_c_ext_or_w4);
	endproperty
	a_tmr_c: assert property (p_tmr_c)
		else $error("tmr_c_run wrong in sub modes");
	property p_pser;
		mode inside {PMS_SUBACTIVE, PMS_SUBSLEEP} |=> pser_run == $past(pser_w2);
	endproperty
	a_pser: assert property (p_pser)
		else $error("pser_run wrong in sub modes");
	property p_tmr_a;
		mode inside {[PMS_WATCH:PMS_SUBSLEEP]}
			|=> tmr_a_run == $past(tmr_a_timebase);
	endproperty
	a_tmr_a: assert property (p_tmr_a)
		else $error("tmr_a_run not tied to time base");
	property p_irq;
		(mode == PMS_WATCH) [*5] |-> irq_set[4:1] == 4'h0;
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq_set raised in watch");
	property p_tmr_g;
		mode == PMS_WATCH |=> tmr_g_run == $past(tmr_g_w4);
	endproperty
	a_tmr_g: assert property (p_tmr_g)
		else $error("tmr_g_run wrong in watch");
	property p_wdog;
		mode == PMS_SUBACTIVE |=> wdog_run == $past(wdog_w32);
	endproperty
	a_wdog: assert property (p_wdog)
		else $error("wdog_run wrong in subactive");
	property p_prst;
		1 |=> pser_rst == ($past(mode) inside {PMS_WATCH, PMS_STANDBY});
	endproperty
	a_prst: assert property (p_prst)
		else $error("pser_rst wrong for mode");
endmodule // pms_top_asserts

bind pms_top pms_top_asserts pms_top_asserts_i (.pclk, .presetn, .mode,
	.sysclk_osc_en, .subclk_osc_en, .port_hiz, .tmr_a_timebase, .tmr_a_run,
	.tmr_c_ext_or_w4, .tmr_c_run, .tmr_g_w4, .tmr_g_run, .pser_w2,
	.pser_run, .pser_rst, .wdog_w32, .wdog_run, .irq_set);

// *** sim/power_mode_state_control_test.sv ***
// Purpose: Self-checking bench of the power mode controller
// Assumes: Zero-wait APB, settling parameters cut to 20 and 40
// Notes: A monitor judges each APB access against a queue of notes
`timescale 1ns/10ps
`include "pms_regs.svh"
module power_mode_state_control_test import pms_pkg::*;;
	typedef struct {logic [7:0] d; logic e;} pms_note_t;
	localparam logic [31:0] addr_one = 32'(`PMS_ADDR_CTRL_ONE);
	localparam logic [31:0] addr_two = 32'(`PMS_ADDR_CTRL_TWO);
	localparam logic [31:0] addr_stat = 32'(`PMS_ADDR_STATUS);
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = '0, pwdata = '0, prdata;
	logic pready, pslverr, sleep_req = 0, wake_req = 0, tmr_a_timebase = 0;
	logic tmr_c_ext_or_w4 = 0, tmr_g_ext_or_w4 = 0, tmr_f_ext_or_w4 = 0;
	logic tmr_g_w4 = 0, tmr_f_w4 = 0, ser_one_ext_or_w4 = 0, pser_w2 = 0;
	logic wdog_w32 = 0, sysclk_osc_en, cpu_on_subclk, ms_tick, port_hiz;
	logic tmr_a_run, tmr_c_run, tmr_g_run, tmr_f_run, wdog_run;
	logic ser_one_run, pser_run, pser_rst, adc_run;
	logic [4:0] irq_pin = '0, irq_set, irq_seen;
	logic [7:0] wakeup_input = '0, wkp_set, wkp_seen, r;
	logic [3:0] mode;
	logic subclk_osc_en, cpu_run, noise_sample_sel;
	logic [1:0] subclk_div_sel;
	int n_mismatch = 0, checks = 0, cyc = 0, k, i;
	int waits[8] = '{20, 40, 1024, 2048, 4096, 2, 8, 16};
	pms_note_t notes[$], nt;

	pms_top #(.WAIT_8192(15'h0014), .WAIT_16384(15'h0028)) pms_top_i (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sleep_req, .wake_req, .tmr_a_timebase,
		.tmr_c_ext_or_w4, .tmr_g_ext_or_w4, .tmr_f_ext_or_w4, .tmr_g_w4,
		.tmr_f_w4, .ser_one_ext_or_w4, .pser_w2, .wdog_w32, .irq_pin,
		.wakeup_input, .mode, .sysclk_osc_en, .subclk_osc_en, .cpu_run,
		.cpu_on_subclk, .ms_tick, .port_hiz, .tmr_a_run, .tmr_c_run,
		.tmr_g_run, .tmr_f_run, .wdog_run, .ser_one_run, .pser_run,
		.pser_rst, .adc_run, .noise_sample_sel, .subclk_div_sel,
		.irq_set, .wkp_set);

	initial forever #12.5 pclk = ~pclk;

	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] x, logic [31:0] got);
		checks++;
		if (got !== x) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, x, got);
		end
	endtask

	task automatic mchk(pms_mode_t m);
		chk("mode", 32'(m), 32'(mode));
	endtask

	// ------------------
	// Drivers
	// ------------------
	task automatic apb(logic wr, logic [31:0] a, logic [7:0] d,
		logic [7:0] x, logic e);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= 32'(d);
		notes.push_back('{x, e});
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask

	// Pulse on sleep_req (w=0) or wake_req (w=1); outputs land two edges on
	task automatic pulse(bit w);
		{wake_req, sleep_req} <= w ? 2'b10 : 2'b01;
		@(posedge pclk);
		{wake_req, sleep_req} <= 2'b00;
		repeat (2) @(posedge pclk);
	endtask

	task automatic settle(bit w, int n);
		int c;
		c = 0;
		{wake_req, sleep_req} <= w ? 2'b10 : 2'b01;
		@(posedge pclk);
		{wake_req, sleep_req} <= 2'b00;
		@(posedge pclk);
		while (mode === PMS_SETTLE && c < 20000) begin
			c++;
			@(posedge pclk);
		end
		chk("settle", n, c);
		@(posedge pclk);
	endtask

	task automatic rnd();
		{tmr_c_ext_or_w4, tmr_g_ext_or_w4, tmr_f_ext_or_w4, tmr_g_w4,
			tmr_f_w4, ser_one_ext_or_w4, pser_w2, wdog_w32} <= 8'($urandom);
		repeat (2) @(posedge pclk);
	endtask

	task automatic gap();
		k = 0;
		while (ms_tick !== 1'b1 && k < 300) begin
			@(posedge pclk);
			k++;
		end
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (ms_tick !== 1'b1 && k < 300);
	endtask

	// ------------------
	// Monitor and limit
	// ------------------
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			test_done();
		end
	end

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
			nt = notes.pop_front();
			chk("pslverr", 32'(nt.e), 32'(pslverr));
			if (!pwrite) chk("prdata", 32'(nt.d), prdata);
		end
	end

	initial begin
		void'($urandom(36974));
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, addr_one, 0, 8'h07, 0);
		apb(0, addr_two, 0, 8'hf0, 0);
		apb(0, 32'h0000_0100, 0, 0, 1);
		r = 8'($urandom);
		apb(1, addr_one, r, 0, 0);
		apb(0, addr_one, 0, (r & 8'hfb) | 8'h04, 0);
		apb(1, addr_two, r, 0, 0);
		apb(0, addr_two, 0, (r & 8'h1f) | 8'he0, 0);
		chk("noise_sample_sel", 32'(r[4]), 32'(noise_sample_sel));
		chk("subclk_div_sel", 32'(r[1:0]), 32'(subclk_div_sel));
		apb(1, addr_stat, r, 0, 1);
		apb(1, addr_two, 8'h00, 0, 0);
		for (i = 0; i < 8; i++) begin
			apb(1, addr_one, 8'h83 | 8'(i << 4), 0, 0);
			pulse(0);
			mchk(PMS_STANDBY);
			chk("port_hiz", 1, port_hiz);
			chk("sysclk_osc_en", 0, sysclk_osc_en);
			chk("subclk_osc_en", 1, subclk_osc_en);
			chk("cpu_run", 0, cpu_run);
			chk("pser_rst", 1, pser_rst);
			chk("adc_run", 0, adc_run);
			settle(1, waits[i]);
			mchk(PMS_ACTIVE_HS);
		end
		apb(1, addr_one, 8'h00, 0, 0);
		pulse(0);
		mchk(PMS_SLEEP_HS);
		chk("cpu_on_subclk", 0, cpu_on_subclk);
		pulse(1);
		mchk(PMS_ACTIVE_HS);
		for (i = 0; i < 4; i++) begin
			apb(1, addr_one, 8'(i), 0, 0);
			apb(1, addr_two, 8'h04, 0, 0);
			pulse(0);
			mchk(PMS_SLEEP_MS);
			pulse(1);
			mchk(PMS_ACTIVE_MS);
			gap();
			chk("ms_tick gap", 16 << i, k);
			apb(1, addr_two, 8'h08, 0, 0);
			pulse(0);
			mchk(PMS_ACTIVE_HS);
		end
		tmr_a_timebase <= 1;
		apb(1, addr_one, 8'h88, 0, 0);
		pulse(0);
		mchk(PMS_SUBACTIVE);
		rnd();
		chk("tmr_c_run", tmr_c_ext_or_w4, tmr_c_run);
		chk("ser_one_run", ser_one_ext_or_w4, ser_one_run);
		chk("pser_run", pser_w2, pser_run);
		chk("wdog_run", wdog_w32, wdog_run);
		chk("tmr_a_run", 1, tmr_a_run);
		chk("cpu_on_subclk", 1, cpu_on_subclk);
		chk("cpu_run", 1, cpu_run);
		apb(1, addr_one, 8'h08, 0, 0);
		apb(1, addr_two, 8'h00, 0, 0);
		pulse(0);
		mchk(PMS_SUBSLEEP);
		rnd();
		chk("tmr_g_run", tmr_g_ext_or_w4, tmr_g_run);
		chk("tmr_f_run", tmr_f_ext_or_w4, tmr_f_run);
		pulse(1);
		mchk(PMS_SUBACTIVE);
		apb(1, addr_one, 8'h88, 0, 0);
		pulse(0);
		mchk(PMS_WATCH);
		rnd();
		chk("tmr_g_run", tmr_g_w4, tmr_g_run);
		chk("tmr_f_run", tmr_f_w4, tmr_f_run);
		irq_pin <= 5'h1f;
		wakeup_input <= 8'hff;
		irq_seen = '0;
		wkp_seen = '0;
		repeat (6) begin
			@(posedge pclk);
			irq_seen |= irq_set;
			wkp_seen |= wkp_set;
		end
		chk("irq_set", 5'h01, irq_seen);
		chk("wkp_set", 8'hff, wkp_seen);
		irq_pin <= '0;
		wakeup_input <= '0;
		pulse(1);
		mchk(PMS_SUBACTIVE);
		apb(1, addr_one, 8'he0, 0, 0);
		apb(1, addr_two, 8'h08, 0, 0);
		settle(0, 8);
		mchk(PMS_ACTIVE_HS);
		apb(1, addr_two, 8'h00, 0, 0);
		pulse(0);
		mchk(PMS_WATCH);
		chk("sysclk_osc_en", 0, sysclk_osc_en);
		settle(1, 8);
		mchk(PMS_ACTIVE_HS);
		chk("notes left", 0, notes.size());
		test_done();
	end
endmodule // power_mode_state_control_test
